//--- pkg/uhpc_defines.vh
/*
 holds the register map, field positions, reset values and timing counts
 of the host power and request control block.
 assumes a 40 MHz system clock and 32-bit APB word addressing.
*/
`ifndef UHPC_DEFINES_VH
`define UHPC_DEFINES_VH

// register byte offsets
`define UHPC_OFF_MODE 8'h00
`define UHPC_OFF_PWRCFG 8'h04
`define UHPC_OFF_PWRCMD 8'h08
`define UHPC_OFF_STATUS 8'h0C
`define UHPC_OFF_HUBADDR 8'h10
`define UHPC_OFF_REQIN 8'h14
`define UHPC_OFF_REQSTAT 8'h18
`define UHPC_OFF_FIFO 8'h1C

// power configuration fields
`define UHPC_CFG_FLT_HIGH 0
`define UHPC_CFG_ACT_LSB 1
`define UHPC_CFG_EN_HIGH 3
`define UHPC_CFG_EN_AUTO 4
`define UHPC_CFG_FILTER 5
`define UHPC_CFG_WIDTH 6
`define UHPC_CFG_RESET 6'h00

// fault action encodings
`define UHPC_ACT_NONE 2'h0
`define UHPC_ACT_TRI 2'h1
`define UHPC_ACT_LOW 2'h2
`define UHPC_ACT_HIGH 2'h3

// power command bits (write-only strobes)
`define UHPC_CMD_PWR_ON 0
`define UHPC_CMD_PWR_OFF 1
`define UHPC_CMD_FLT_ON 2
`define UHPC_CMD_FLT_OFF 3

// status bits
`define UHPC_ST_FAULT 0
`define UHPC_ST_STDONE 1
`define UHPC_ST_BUSY 2
`define UHPC_ST_VBUS 3
`define UHPC_ST_PWRON 4
`define UHPC_ST_FLTEN 5

// hub address write fields
`define UHPC_HUB_ADDR_LSB 0
`define UHPC_HUB_EP_LSB 8
`define UHPC_HUB_DIR_BIT 12
`define UHPC_HUB_RESET 8'h00

// vbus glitch filter: drop must last this long to count
`define UHPC_GLITCH_NS 1000
`define UHPC_CLK_MHZ 40
`define UHPC_GLITCH_CYC ((`UHPC_GLITCH_NS * `UHPC_CLK_MHZ) / 1000)

`endif

//--- core/uhpc_ctrl.v
/*
 host-mode power switch control, per-endpoint hub addresses, IN and
 status request scheduling and a receive buffer, all behind an APB slave.
 assumes a transaction engine on the txn* ports that takes one request at
 a time and answers with a done pulse, and rx data pushed with valid/ready.
*/
// Added by the designer: the register addresses and the APB register port.
// Contract
// - software command switches controller into host role, enabling host features
// - readable hub address kept per endpoint, separately for IN and OUT
// - hub address write replaces only chosen endpoint and direction entry
// - drive power-enable output, sample power-fault input per configuration
// - polarity setting picks low or high fault level
// - detected fault applies chosen action: tristate, drive low, drive high
// - action none leaves power-enable output unchanged on fault
// - manual mode drives configured active level on power-enable command
// - automatic mode drives active level while OTG session is enabled
// - glitch filter ignores short VBUS drops
// - power-enable command asserts power-enable output
// - power-disable command deasserts power-enable output
// - fault detection activated by enable command
// - disable command stops fault detection and fault actions
// - request command schedules IN transaction on given endpoint
// - returned IN data readable from FIFO by processor or DMA
// - status request issues status IN on endpoint zero
// - interrupt signalled when requested status packet received
`timescale 1ns/10ps
`default_nettype none
`include "uhpc_defines.vh"

module uhpc_ctrl #(
	parameter EP_BITS = 4,
	parameter FIFO_BITS = 3,
	parameter GLITCH_CYC = `UHPC_GLITCH_CYC
) (
	input wire clk_sys, // 40 MHz clock
	input wire rst_n, // sync reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error on unmapped
	output reg power_enable_out, // supply enable pin level
	output reg powerEnableOe, // supply enable pin driven
	input wire power_fault_in, // supply fault pin
	input wire vbusLevelIn, // raw vbus valid comparator
	output reg vbusValid, // filtered vbus valid
	input wire sessionActive, // otg session enabled
	output reg txnReq, // transaction request pulse
	output reg [EP_BITS-1:0] txnEp, // endpoint of request
	output reg [7:0] txnHubAddr, // IN hub address of endpoint
	output reg txnStatus, // request is a status IN on ep0
	input wire txnDone, // engine finished request
	input wire rxValid, // received byte valid
	input wire [7:0] rxData, // received byte
	output reg rxReady, // buffer can take a byte
	output reg dmaReq, // buffer holds data for dma
	input wire dmaAck, // dma took head byte
	output reg [7:0] dmaData, // head byte for dma
	output reg irqOut // fault or status done pending
);
	localparam NEP = 1 << EP_BITS;
	localparam DEPTH = 1 << FIFO_BITS;
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ISSUE = 2'h1;
	localparam [1:0] ST_WAIT = 2'h2;

	reg hostMode;
	reg [`UHPC_CFG_WIDTH-1:0] pwrCfg;
	reg pwrOn;
	reg faultDetEn;
	reg faultFlag;
	reg faultHold;
	reg statusDoneFlag;
	reg [7:0] hubMem [0:2*NEP-1];
	reg [EP_BITS:0] hubSel;
	reg [NEP-1:0] inPending;
	reg statusPending;
	reg [1:0] state;
	reg curStatus;
	reg [15:0] glitchCnt;
	reg faultSeen;
	reg [7:0] fifoMem [0:DEPTH-1];
	reg [FIFO_BITS:0] wrPtr;
	reg [FIFO_BITS:0] rdPtr;
	reg [EP_BITS-1:0] next_ep;
	reg next_found;
	integer i;
	integer k;

	wire apbSetup = psel & ~penable;
	wire apbDone = psel & penable & pready;
	wire wrDone = apbDone & pwrite;
	wire rdDone = apbDone & ~pwrite;
	wire fifoEmpty = (wrPtr == rdPtr);
	wire fifoFull = (wrPtr[FIFO_BITS] != rdPtr[FIFO_BITS]) &&
		(wrPtr[FIFO_BITS-1:0] == rdPtr[FIFO_BITS-1:0]);
	wire [1:0] faultAct = pwrCfg[`UHPC_CFG_ACT_LSB+1:`UHPC_CFG_ACT_LSB];

	// address decode for the error answer; the read mux decodes with its own case
	function isMapped;
		input [7:0] a;
		begin
			isMapped = (a == `UHPC_OFF_MODE) || (a == `UHPC_OFF_PWRCFG) ||
				(a == `UHPC_OFF_PWRCMD) || (a == `UHPC_OFF_STATUS) ||
				(a == `UHPC_OFF_HUBADDR) || (a == `UHPC_OFF_REQIN) ||
				(a == `UHPC_OFF_REQSTAT) || (a == `UHPC_OFF_FIFO);
		end
	endfunction

	// a strobe for one register at the completing edge of a write, or of a read for the fifo pop
	function regWr;
		input [7:0] a;
		input [7:0] off;
		input done;
		begin
			regWr = done && (a == off);
		end
	endfunction

	wire cmdWr = regWr(paddr, `UHPC_OFF_PWRCMD, wrDone);
	wire stWr = regWr(paddr, `UHPC_OFF_STATUS, wrDone);
	wire fifoPopCpu = regWr(paddr, `UHPC_OFF_FIFO, rdDone) & ~fifoEmpty;
	wire fifoPopDma = dmaAck & ~fifoEmpty & ~fifoPopCpu;
	wire fifoPush = rxValid & rxReady;

	// fault level compare; detection only while enabled and in host role
	wire faultLevel = (power_fault_in == pwrCfg[`UHPC_CFG_FLT_HIGH]);
	wire faultNow = faultLevel & faultDetEn & hostMode;

	// apb answer: no wait states, ready registered from the setup cycle and high in the first access cycle
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= apbSetup;
			pslverr <= apbSetup & ~isMapped(paddr);
			if (apbSetup && !pwrite) begin
				case (paddr)
				`UHPC_OFF_MODE: prdata <= {31'h00000000, hostMode};
				`UHPC_OFF_PWRCFG: prdata <= {26'h0000000, pwrCfg};
				`UHPC_OFF_STATUS: prdata <= {26'h0000000, faultDetEn, pwrOn,
					vbusValid, (state != ST_IDLE) | statusPending | (|inPending),
					statusDoneFlag, faultFlag};
				`UHPC_OFF_HUBADDR: prdata <= {19'h00000, hubSel, hubMem[hubSel]};
				`UHPC_OFF_REQIN: prdata <= {{(32-NEP){1'b0}}, inPending};
				`UHPC_OFF_REQSTAT: prdata <= {31'h00000000, statusPending};
				`UHPC_OFF_FIFO: prdata <= {23'h000000, fifoEmpty,
					fifoMem[rdPtr[FIFO_BITS-1:0]]};
				default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// role and power configuration; config writes need host role
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			hostMode <= 1'b0;
			pwrCfg <= `UHPC_CFG_RESET;
		end else begin
			if (regWr(paddr, `UHPC_OFF_MODE, wrDone))
				hostMode <= pwdata[0];
			if (regWr(paddr, `UHPC_OFF_PWRCFG, wrDone) && hostMode)
				pwrCfg <= pwdata[`UHPC_CFG_WIDTH-1:0];
		end
	end

	// power and fault-detect commands; fault flag set wins over clear
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			pwrOn <= 1'b0;
			faultDetEn <= 1'b0;
			faultFlag <= 1'b0;
			faultHold <= 1'b0;
			faultSeen <= 1'b0;
		end else begin
			if (cmdWr && hostMode && pwdata[`UHPC_CMD_PWR_ON])
				pwrOn <= 1'b1;
			else if (cmdWr && hostMode && pwdata[`UHPC_CMD_PWR_OFF])
				pwrOn <= 1'b0;
			if (cmdWr && hostMode && pwdata[`UHPC_CMD_FLT_ON])
				faultDetEn <= 1'b1;
			else if (cmdWr && pwdata[`UHPC_CMD_FLT_OFF])
				faultDetEn <= 1'b0;
			faultSeen <= faultNow;
			// flag rises on a new fault; a level fault is one event
			if (faultNow && !faultSeen)
				faultFlag <= 1'b1;
			else if (stWr && pwdata[`UHPC_ST_FAULT])
				faultFlag <= 1'b0;
			// action holds until software turns detect off, or turns power off once the fault is gone
			if (faultNow)
				faultHold <= 1'b1;
			else if (!faultDetEn || (cmdWr && pwdata[`UHPC_CMD_PWR_OFF]))
				faultHold <= 1'b0;
		end
	end

	// power-enable pin: source level first, then any fault override
	wire srcOn = pwrCfg[`UHPC_CFG_EN_AUTO] ? sessionActive : pwrOn;
	wire baseLevel = srcOn ? pwrCfg[`UHPC_CFG_EN_HIGH] : ~pwrCfg[`UHPC_CFG_EN_HIGH];
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			power_enable_out <= 1'b0;
			powerEnableOe <= 1'b0;
		end else if (!hostMode) begin
			// pin released outside host role, supply left to board pulls
			power_enable_out <= 1'b0;
			powerEnableOe <= 1'b0;
		end else if (faultHold) begin
			case (faultAct)
			`UHPC_ACT_TRI: begin
				power_enable_out <= 1'b0;
				powerEnableOe <= 1'b0;
			end
			`UHPC_ACT_LOW: begin
				power_enable_out <= 1'b0;
				powerEnableOe <= 1'b1;
			end
			`UHPC_ACT_HIGH: begin
				power_enable_out <= 1'b1;
				powerEnableOe <= 1'b1;
			end
			default: begin
				power_enable_out <= baseLevel;
				powerEnableOe <= 1'b1;
			end
			endcase
		end else begin
			power_enable_out <= baseLevel;
			powerEnableOe <= 1'b1;
		end
	end

	// vbus valid: a drop must last the filter window when filter is on
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			glitchCnt <= 16'h0000;
			vbusValid <= 1'b0;
		end else if (vbusLevelIn) begin
			glitchCnt <= 16'h0000;
			vbusValid <= 1'b1;
		end else if (!pwrCfg[`UHPC_CFG_FILTER] || glitchCnt >= GLITCH_CYC[15:0] - 16'h0001) begin
			vbusValid <= 1'b0;
		end else begin
			glitchCnt <= glitchCnt + 16'h0001;
		end
	end

	// hub address table; select latches on every write for read-back
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			hubSel <= {(EP_BITS+1){1'b0}};
			for (i = 0; i < 2*NEP; i = i + 1)
				hubMem[i] <= `UHPC_HUB_RESET;
		end else if (regWr(paddr, `UHPC_OFF_HUBADDR, wrDone) && hostMode) begin
			hubSel <= {pwdata[`UHPC_HUB_EP_LSB+EP_BITS-1:`UHPC_HUB_EP_LSB],
				pwdata[`UHPC_HUB_DIR_BIT]};
			if (pwdata[`UHPC_HUB_DIR_BIT+1])
				hubMem[{pwdata[`UHPC_HUB_EP_LSB+EP_BITS-1:`UHPC_HUB_EP_LSB],
					pwdata[`UHPC_HUB_DIR_BIT]}] <= pwdata[7:0];
		end
	end

	// lowest pending endpoint wins; fixed priority keeps the mux small
	always @* begin
		next_ep = {EP_BITS{1'b0}};
		next_found = 1'b0;
		for (k = NEP - 1; k >= 0; k = k - 1) begin
			if (inPending[k]) begin
				next_ep = k[EP_BITS-1:0];
				next_found = 1'b1;
			end
		end
	end

	// request scheduler: status request ahead of plain IN requests
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			inPending <= {NEP{1'b0}};
			statusPending <= 1'b0;
			statusDoneFlag <= 1'b0;
			state <= ST_IDLE;
			curStatus <= 1'b0;
			txnReq <= 1'b0;
			txnEp <= {EP_BITS{1'b0}};
			txnHubAddr <= 8'h00;
			txnStatus <= 1'b0;
		end else begin
			txnReq <= 1'b0;
			if (regWr(paddr, `UHPC_OFF_REQIN, wrDone) && hostMode)
				inPending[pwdata[EP_BITS-1:0]] <= 1'b1;
			if (regWr(paddr, `UHPC_OFF_REQSTAT, wrDone) && hostMode && pwdata[0])
				statusPending <= 1'b1;
			case (state)
			ST_IDLE: begin
				if (statusPending) begin
					statusPending <= 1'b0;
					curStatus <= 1'b1;
					txnEp <= {EP_BITS{1'b0}};
					txnHubAddr <= hubMem[1];
					state <= ST_ISSUE;
				end else if (next_found) begin
					inPending[next_ep] <= 1'b0;
					curStatus <= 1'b0;
					txnEp <= next_ep;
					txnHubAddr <= hubMem[{next_ep, 1'b1}];
					state <= ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				txnReq <= 1'b1;
				txnStatus <= curStatus;
				state <= ST_WAIT;
			end
			ST_WAIT: begin
				if (txnDone)
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
			// done flag set wins over a same-cycle clear
			if (state == ST_WAIT && txnDone && curStatus)
				statusDoneFlag <= 1'b1;
			else if (stWr && pwdata[`UHPC_ST_STDONE])
				statusDoneFlag <= 1'b0;
		end
	end

	// receive buffer: engine pushes, cpu read or dma ack pops
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			wrPtr <= {(FIFO_BITS+1){1'b0}};
			rdPtr <= {(FIFO_BITS+1){1'b0}};
		end else begin
			if (fifoPush) begin
				fifoMem[wrPtr[FIFO_BITS-1:0]] <= rxData;
				wrPtr <= wrPtr + 1'b1;
			end
			if (fifoPopCpu || fifoPopDma)
				rdPtr <= rdPtr + 1'b1;
		end
	end

	// registered buffer flags and interrupt line
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rxReady <= 1'b0;
			dmaReq <= 1'b0;
			dmaData <= 8'h00;
			irqOut <= 1'b0;
		end else begin
			// conservative: ready drops as a push fills the last slot, ignoring a same-cycle pop, so no push is lost
			rxReady <= ~fifoFull && !(fifoPush &&
				(wrPtr[FIFO_BITS-1:0] + 1'b1 == rdPtr[FIFO_BITS-1:0]));
			dmaReq <= (wrPtr != rdPtr) && !((fifoPopCpu || fifoPopDma) &&
				!fifoPush && (rdPtr + 1'b1 == wrPtr));
			dmaData <= (fifoPopCpu || fifoPopDma) ?
				fifoMem[rdPtr[FIFO_BITS-1:0] + 1'b1] : fifoMem[rdPtr[FIFO_BITS-1:0]];
			irqOut <= faultFlag | statusDoneFlag;
		end
	end
endmodule

`default_nettype wire

//--- bench/uhpc_checker.sv
/*
 uhpc_checker: port assertions for uhpc_ctrl.
 assumes it is bound onto the design from tb_top.
*/
`timescale 1ns/10ps
`default_nettype none
module uhpc_checker #(
	parameter EP_BITS = 4
) (
	input wire logic clk_sys, // clock
	input wire logic rst_n, // sync reset
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic vbusLevelIn, // raw vbus
	input wire logic vbusValid, // filtered vbus
	input wire logic txnReq, // request pulse
	input wire logic [EP_BITS-1:0] txnEp, // request ep
	input wire logic [7:0] txnHubAddr, // request hub
	input wire logic txnStatus, // status request
	input wire logic txnDone, // engine done
	input wire logic rxValid, // rx push
	input wire logic rxReady, // rx room
	input wire logic dmaReq, // data for dma
	input wire logic irqOut // interrupt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// apb phases
	sequence apbSetup;
		psel && !penable;
	endsequence
	sequence apbAccess;
		psel && penable && pready;
	endsequence
	a_ready_after_setup: assert property (
		apbSetup |=> apbAccess ##1 !pready) else $error("pready timing wrong");
	a_ready_in_access: assert property (
		pready |-> psel && penable) else $error("pready outside access");
	a_error_with_ready: assert property (
		pslverr |-> pready) else $error("pslverr without pready");
	a_request_pulse_held: assert property (
		txnReq |=> !txnReq && $stable(txnEp) && $stable(txnHubAddr))
		else $error("request not a held pulse");
	a_status_on_ep0: assert property (
		txnReq && txnStatus |-> txnEp == '0) else $error("status not on ep0");
	a_status_done_irq: assert property (
		txnStatus && txnDone |-> ##[1:2] irqOut) else $error("no irq on status done");
	a_vbus_rise_fast: assert property (
		rst_n && vbusLevelIn |=> vbusValid) else $error("vbus valid slow to rise");
	a_push_shows_dma: assert property (
		rxValid && rxReady && !dmaReq |-> ##[1:2] dmaReq) else $error("pushed byte unseen");
endmodule
`default_nettype wire

//--- bench/uhpc_partner.sv
/*
 uhpc_partner: far side model, a device answering scheduled transactions
 and a supply switch whose fault pin the bench can trip.
 assumes one request at a time from the controller.
*/
`timescale 1ns/10ps
`default_nettype none
module uhpc_partner (
	input wire logic clk_sys, // clock
	input wire logic txnReq, // request pulse
	input wire logic [3:0] txnEp, // request endpoint
	input wire logic txnStatus, // status request
	output logic txnDone, // completion pulse
	output logic rxValid, // byte offered
	output logic [7:0] rxData, // byte value
	input wire logic rxReady, // buffer room
	input wire logic slow, // long reply delay
	input wire logic overload, // supply in fault
	input wire logic faultHigh, // fault pin polarity
	output logic power_fault_in // fault pin level
);
	// pin shows the fault level only while overloaded
	assign power_fault_in = overload ? faultHigh : !faultHigh;
	// idle levels at time zero
	initial begin
		txnDone = 1'b0;
		rxValid = 1'b0;
		rxData = 8'h00;
	end
	// reply: wait, hand one byte for IN, then pulse done
	always begin
		@(posedge clk_sys);
		if (txnReq) begin
			repeat (slow ? 8 : 1) @(posedge clk_sys);
			if (!txnStatus) begin
				rxValid <= 1'b1;
				rxData <= {4'hA, txnEp};
				do @(posedge clk_sys); while (!rxReady);
				rxValid <= 1'b0;
				rxData <= ~{4'hA, txnEp}; // released data must not look valid
			end
			txnDone <= 1'b1;
			@(posedge clk_sys);
			txnDone <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
/*
 tb_top: self-checking bench for uhpc_ctrl with partner and checker.
 assumes a 40 MHz clock and a filter count of 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uhpc_defines.vh"
module tb_top;
	logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00, txnHubAddr, rxData, dmaData;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, pwrOut, pwrOe, faultPin, vbusLevelIn = 1, vbusValid, irqOut;
	logic sessionActive = 0, txnReq, txnStatus, txnDone, rxValid, rxReady, dmaReq, dmaAck = 0;
	logic slow = 0, overload = 0, faultHigh = 1;
	logic [3:0] txnEp;
	logic [7:0] hubSeen;
	int miscompares = 0, num_checks = 0;
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	uhpc_ctrl #(.GLITCH_CYC(4)) uhpc_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .power_enable_out(pwrOut),
		.powerEnableOe(pwrOe), .power_fault_in(faultPin), .vbusLevelIn(vbusLevelIn),
		.vbusValid(vbusValid), .sessionActive(sessionActive), .txnReq(txnReq), .txnEp(txnEp),
		.txnHubAddr(txnHubAddr), .txnStatus(txnStatus), .txnDone(txnDone), .rxValid(rxValid),
		.rxData(rxData), .rxReady(rxReady), .dmaReq(dmaReq), .dmaAck(dmaAck),
		.dmaData(dmaData), .irqOut(irqOut));
	uhpc_partner uhpc_partner_inst (.clk_sys(clk_sys), .txnReq(txnReq), .txnEp(txnEp),
		.txnStatus(txnStatus), .txnDone(txnDone), .rxValid(rxValid), .rxData(rxData),
		.rxReady(rxReady), .slow(slow), .overload(overload), .faultHigh(faultHigh),
		.power_fault_in(faultPin));
	// hub address carried by the latest request, for the request scenarios
	always @(posedge clk_sys) begin
		if (txnReq) hubSeen <= txnHubAddr;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic stop(input string s);
		miscompares++;
		$display("CHECK FAILED %s expected done seen timeout", s);
		results();
	endtask
	// one apb transfer; waits for pready under a bound, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) stop("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd & m);
	endtask
	task automatic waitStat(input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do begin
			apb(1'b0, `UHPC_OFF_STATUS, 32'h0);
			n++;
		end while ((rd & m) !== e && n < 40);
		if ((rd & m) !== e) stop("status");
	endtask
	// pin sampled mid-cycle, well after the cause has settled
	task automatic pin(input string s, input logic [1:0] e);
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(s, {30'h0, e}, {30'h0, pwrOe, pwrOut});
		@(posedge clk_sys);
	endtask
	task automatic vchk(input string s, input logic e);
		@(negedge clk_sys);
		chk(s, {31'h0, e}, {31'h0, vbusValid});
		@(posedge clk_sys);
	endtask
	task automatic tHost();
		wr(`UHPC_OFF_PWRCFG, 32'h8);
		rdc("cfg pre host", `UHPC_OFF_PWRCFG, 32'h3F, 32'h0);
		pin("pin pre host", 2'b00);
		wr(`UHPC_OFF_MODE, 32'h1);
		rdc("mode", `UHPC_OFF_MODE, 32'h1, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
	endtask
	// checked ep3 entries stored first, so a later wide write would clobber them
	task automatic tHub();
		wr(`UHPC_OFF_HUBADDR, 32'h3355);
		wr(`UHPC_OFF_HUBADDR, 32'h2366);
		wr(`UHPC_OFF_HUBADDR, 32'h3277);
		wr(`UHPC_OFF_HUBADDR, 32'h1300);
		rdc("hub ep3 in", `UHPC_OFF_HUBADDR, 32'hFF, 32'h55);
		wr(`UHPC_OFF_HUBADDR, 32'h0300);
		rdc("hub ep3 out", `UHPC_OFF_HUBADDR, 32'hFF, 32'h66);
	endtask
	task automatic tPower();
		for (int l = 0; l < 2; l++) begin
			wr(`UHPC_OFF_PWRCFG, l << 3);
			wr(`UHPC_OFF_PWRCMD, 32'h1);
			pin("power on", {1'b1, l[0]});
			wr(`UHPC_OFF_PWRCMD, 32'h2);
			pin("power off", {1'b1, !l[0]});
		end
	endtask
	task automatic tFault();
		logic [1:0] ex [4] = '{2'b11, 2'b00, 2'b10, 2'b11};
		for (int a = 0; a < 4; a++) begin
			wr(`UHPC_OFF_PWRCFG, 32'h9 | (a << 1));
			wr(`UHPC_OFF_PWRCMD, 32'h5);
			overload <= 1'b1;
			pin("fault action", ex[a]);
			rdc("fault flag", `UHPC_OFF_STATUS, 32'h1, 32'h1);
			chk("fault irq", 32'h1, {31'h0, irqOut});
			overload <= 1'b0;
			wr(`UHPC_OFF_PWRCMD, 32'hA);
			wr(`UHPC_OFF_STATUS, 32'h1);
		end
		wr(`UHPC_OFF_PWRCFG, 32'hE);
		faultHigh <= 1'b0;
		overload <= 1'b1;
		pin("detect off", 2'b10);
		wr(`UHPC_OFF_PWRCMD, 32'h4);
		pin("detect on", 2'b11);
		wr(`UHPC_OFF_PWRCMD, 32'hA);
		overload <= 1'b0;
		faultHigh <= 1'b1;
		wr(`UHPC_OFF_STATUS, 32'h1);
	endtask
	task automatic tSession();
		wr(`UHPC_OFF_PWRCFG, 32'h18);
		pin("no session", 2'b10);
		sessionActive <= 1'b1;
		pin("session", 2'b11);
		sessionActive <= 1'b0;
	endtask
	// drops of 2, 8 and 1 cycles against a count of 4
	task automatic tFilter();
		wr(`UHPC_OFF_PWRCFG, 32'h20);
		vbusLevelIn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		vbusLevelIn <= 1'b1;
		vchk("short drop", 1'b1);
		vbusLevelIn <= 1'b0;
		repeat (8) @(posedge clk_sys);
		vchk("long drop", 1'b0);
		vbusLevelIn <= 1'b1;
		wr(`UHPC_OFF_PWRCFG, 32'h0);
		vbusLevelIn <= 1'b0;
		@(posedge clk_sys);
		vchk("no filter", 1'b0);
		vbusLevelIn <= 1'b1;
	endtask
	task automatic tReq();
		wr(`UHPC_OFF_REQIN, 32'h5);
		wr(`UHPC_OFF_REQIN, 32'h2);
		waitStat(32'h4, 32'h0);
		chk("hub used", 32'h77, {24'h0, hubSeen});
		rdc("cpu byte", `UHPC_OFF_FIFO, 32'h1FF, 32'hA5);
		chk("dma byte", 32'hA2, {24'h0, dmaData});
		chk("dma request", 32'h1, {31'h0, dmaReq});
		dmaAck <= 1'b1;
		@(posedge clk_sys);
		dmaAck <= 1'b0;
		@(posedge clk_sys);
		chk("dma idle", 32'h0, {31'h0, dmaReq});
		rdc("fifo empty", `UHPC_OFF_FIFO, 32'h100, 32'h100);
	endtask
	task automatic tStatus();
		slow <= 1'b1;
		wr(`UHPC_OFF_REQSTAT, 32'h1);
		waitStat(32'h2, 32'h2);
		chk("status irq", 32'h1, {31'h0, irqOut});
		wr(`UHPC_OFF_STATUS, 32'h2);
		@(posedge clk_sys);
		chk("irq cleared", 32'h0, {31'h0, irqOut});
	endtask
	// mid-run reset drops host role and releases the supply pin
	task automatic tReset();
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rdc("mode after reset", `UHPC_OFF_MODE, 32'h1, 32'h0);
		pin("pin after reset", 2'b00);
	endtask
	// reset, then scenarios in order
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		tHost();
		tHub();
		tPower();
		tFault();
		tSession();
		tFilter();
		tReq();
		tStatus();
		tReset();
		results();
	end
	// cut a hang short
	initial begin
		repeat (50000) @(posedge clk_sys);
		stop("run");
	end
endmodule
bind uhpc_ctrl uhpc_checker #(.EP_BITS(EP_BITS)) uhpc_checker_inst (.clk_sys(clk_sys),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.vbusLevelIn(vbusLevelIn), .vbusValid(vbusValid), .txnReq(txnReq), .txnEp(txnEp),
	.txnHubAddr(txnHubAddr), .txnStatus(txnStatus), .txnDone(txnDone), .rxValid(rxValid),
	.rxReady(rxReady), .dmaReq(dmaReq), .irqOut(irqOut));
`default_nettype wire
